// File: logic/link_training_control.sv
// link training control: ability advertisement, training sequencing and frame fields
// Function
// - each protocol ability input drives its advertised bit, one means supported
// - training enable low skips training, lanes run in mission mode
// - restart input restarts training from the beginning in the training and trained states, ignored in mission mode
// - per-lane preset input goes into the frame control block preset bit
// - per-lane initialize input goes into the frame control block initialize bit
// - lane pattern generator is seeded from its 11-bit seed input
// - three 2-bit tap update requests sent in the control block
// - three 2-bit tap update status fields sent in the status block
// - direct training control ports used only without the register interface option, else registers; ability inputs are always direct
`timescale 1ns/1ps
`default_nettype none

module link_training_control
    import link_training_pkg::*;
#(
    parameter logic REG_IF_SEL = 1'b0
) (
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    // ability inputs
    input  wire logic                 adv_gig_kx_ability_in,
    input  wire logic                 adv_ten_kx4_ability_in,
    input  wire logic                 adv_ten_kr_ability_in,
    input  wire logic                 adv_forty_kr4_ability_in,
    input  wire logic                 adv_forty_cr4_ability_in,
    input  wire logic                 adv_hundred_cr10_ability_in,
    input  wire logic                 adv_hundred_kp4_ability_in,
    input  wire logic                 adv_hundred_kr4_ability_in,
    input  wire logic                 adv_hundred_cr4_ability_in,
    input  wire logic                 adv_twentyfive_krcr_short_ability_in,
    input  wire logic                 adv_twentyfive_krcr_ability_in,
    input  wire logic                 adv_twentyfive_kr1_ability_in,
    input  wire logic                 adv_twentyfive_cr1_ability_in,
    input  wire logic                 adv_fifty_kr2_ability_in,
    input  wire logic                 adv_fifty_cr2_ability_in,
    // direct training controls
    input  wire logic                 training_enable_in,
    input  wire logic                 training_restart_in,
    input  wire logic [LANES-1:0]     lane_receiver_done_in,
    input  wire logic [LANES-1:0]     frame_preset_bit_in,
    input  wire logic [LANES-1:0]     frame_init_bit_in,
    input  wire logic [SEED_W-1:0]    lane0_pattern_seed_in,
    input  wire logic [COEF_W-1:0]    lane0_post_tap_request_in,
    input  wire logic [COEF_W-1:0]    lane0_main_tap_request_in,
    input  wire logic [COEF_W-1:0]    lane0_pre_tap_request_in,
    input  wire logic [COEF_W-1:0]    lane0_post_tap_status_in,
    input  wire logic [COEF_W-1:0]    lane0_main_tap_status_in,
    input  wire logic [COEF_W-1:0]    lane0_pre_tap_status_in,
    // register-sourced settings
    input  wire lt_settings_t         reg_settings_in,
    // link codeword and training frame fields
    output logic [ABILITY_W-1:0]      adv_ability_out,
    output logic [LANES-1:0]          frame_preset_out,
    output logic [LANES-1:0]          frame_init_out,
    output logic [TAPS_W-1:0]         lane0_tap_request_out,
    output logic [TAPS_W-1:0]         lane0_tap_status_out,
    output logic [LANES-1:0]          lane_receiver_ready_out,
    output logic                      frame_start_out,
    output logic                      lane0_pattern_bit_out,
    // training status
    output logic                      mission_mode_out,
    output logic                      training_active_out,
    output logic                      training_done_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        train_state_t           st;
        logic [FRAME_CNT_W-1:0] beat;
        logic [ABILITY_W-1:0]   adv;
        logic [LANES-1:0]       preset;
        logic [LANES-1:0]       init;
        logic [TAPS_W-1:0]      req;
        logic [TAPS_W-1:0]      stat;
        logic [LANES-1:0]       rx_ready;
        logic [SEED_W-1:0]      prbs;
        logic                   frame_start;
    } ctl_state_t;

    localparam ctl_state_t CTL_RST = '{
        st:          ST_MISSION,
        beat:        FRAME_CNT_ZERO,
        adv:         ABILITY_RST,
        preset:      LANE_RST,
        init:        LANE_RST,
        req:         TAPS_RST,
        stat:        TAPS_RST,
        rx_ready:    LANE_RST,
        prbs:        SEED_RST,
        frame_start: 1'b0
    };

    ctl_state_t   ctl_r;
    ctl_state_t   ctl_nxt;
    lt_settings_t direct_set;
    lt_settings_t set_sel;
    logic         fresh_start;
    logic         frame_wrap;
    logic         prbs_fb;
    logic [SEED_W-1:0] seed_use;

    // ------------------------------------------------------------
    // settings source
    // ------------------------------------------------------------
    always_comb begin
        direct_set.training_enable    = training_enable_in;
        direct_set.training_restart   = training_restart_in;
        direct_set.lane_receiver_done = lane_receiver_done_in;
        direct_set.frame_preset_bit   = frame_preset_bit_in;
        direct_set.frame_init_bit     = frame_init_bit_in;
        direct_set.lane0_pattern_seed = lane0_pattern_seed_in;
        direct_set.lane0_tap_request  = {lane0_post_tap_request_in,
                                         lane0_main_tap_request_in,
                                         lane0_pre_tap_request_in};
        direct_set.lane0_tap_status   = {lane0_post_tap_status_in,
                                         lane0_main_tap_status_in,
                                         lane0_pre_tap_status_in};
        // the option is fixed at build time, so only one source is ever live
        set_sel = REG_IF_SEL ? reg_settings_in : direct_set;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        ctl_nxt     = ctl_r;
        fresh_start = 1'b0;
        frame_wrap  = 1'b0;
        // an all-zero seed would lock the generator, so it is swapped for ones
        seed_use    = (set_sel.lane0_pattern_seed == SEED_ZERO) ? SEED_RST
                                                               : set_sel.lane0_pattern_seed;
        prbs_fb     = ctl_r.prbs[PRBS_TAP_HI] ^ ctl_r.prbs[PRBS_TAP_LO];

        ctl_nxt.adv = {adv_fifty_cr2_ability_in,
                       adv_fifty_kr2_ability_in,
                       adv_twentyfive_cr1_ability_in,
                       adv_twentyfive_kr1_ability_in,
                       adv_twentyfive_krcr_ability_in,
                       adv_twentyfive_krcr_short_ability_in,
                       adv_hundred_cr4_ability_in,
                       adv_hundred_kr4_ability_in,
                       adv_hundred_kp4_ability_in,
                       adv_hundred_cr10_ability_in,
                       adv_forty_cr4_ability_in,
                       adv_forty_kr4_ability_in,
                       adv_ten_kr_ability_in,
                       adv_ten_kx4_ability_in,
                       adv_gig_kx_ability_in};

        case (ctl_r.st)
            ST_MISSION: begin
                if (set_sel.training_enable) begin
                    fresh_start = 1'b1;
                end
            end
            ST_TRAIN: begin
                if (!set_sel.training_enable) begin
                    ctl_nxt.st = ST_MISSION;
                end else if (set_sel.training_restart) begin
                    fresh_start = 1'b1;
                end else if (ctl_r.rx_ready == LANE_ALL) begin
                    ctl_nxt.st = ST_TRAINED;
                end
            end
            ST_TRAINED: begin
                if (!set_sel.training_enable) begin
                    ctl_nxt.st = ST_MISSION;
                end else if (set_sel.training_restart) begin
                    fresh_start = 1'b1;
                end
            end
            default: begin
                ctl_nxt.st = ST_MISSION;
            end
        endcase

        if (ctl_nxt.st == ST_MISSION && !fresh_start) begin
            ctl_nxt.beat        = FRAME_CNT_ZERO;
            ctl_nxt.frame_start = 1'b0;
        end else if (fresh_start) begin
            ctl_nxt.st          = ST_TRAIN;
            ctl_nxt.beat        = FRAME_CNT_ZERO;
            ctl_nxt.prbs        = seed_use;
            ctl_nxt.frame_start = 1'b1;
            frame_wrap          = 1'b1;
            ctl_nxt.rx_ready    = LANE_RST;
        end else begin
            frame_wrap          = (ctl_r.beat == FRAME_BEATS - FRAME_CNT_ONE);
            ctl_nxt.beat        = frame_wrap ? FRAME_CNT_ZERO : ctl_r.beat + FRAME_CNT_ONE;
            ctl_nxt.prbs        = {ctl_r.prbs[SEED_W-2:0], prbs_fb};
            ctl_nxt.frame_start = frame_wrap;
        end

        // fields change only at a frame boundary so no frame carries mixed values
        if (frame_wrap) begin
            ctl_nxt.preset   = set_sel.frame_preset_bit;
            ctl_nxt.init     = set_sel.frame_init_bit;
            ctl_nxt.req      = set_sel.lane0_tap_request;
            ctl_nxt.stat     = set_sel.lane0_tap_status;
        end
        if (frame_wrap && !fresh_start) begin
            ctl_nxt.rx_ready = set_sel.lane_receiver_done;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_r <= CTL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign adv_ability_out         = ctl_r.adv;
    assign frame_preset_out        = ctl_r.preset;
    assign frame_init_out          = ctl_r.init;
    assign lane0_tap_request_out   = ctl_r.req;
    assign lane0_tap_status_out    = ctl_r.stat;
    assign lane_receiver_ready_out = ctl_r.rx_ready;
    assign frame_start_out         = ctl_r.frame_start;
    assign lane0_pattern_bit_out   = ctl_r.prbs[PRBS_TAP_HI];
    assign mission_mode_out        = (ctl_r.st == ST_MISSION);
    assign training_active_out     = (ctl_r.st == ST_TRAIN);
    assign training_done_out       = (ctl_r.st == ST_TRAINED);

endmodule

`default_nettype wire

// File: logic/link_training_pkg.sv
// constants and types shared by the link training control block
package link_training_pkg;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int LANES       = 4;
    localparam int ABILITY_W   = 15;
    localparam int SEED_W      = 11;
    localparam int COEF_W      = 2;
    localparam int TAP_FIELDS  = 3;
    localparam int TAPS_W      = COEF_W * TAP_FIELDS;
    localparam int FRAME_CNT_W = 10;

    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    // one training frame is 4384 bit times, carried here as byte beats
    localparam int                     FRAME_BITS     = 4384;
    localparam int                     BEAT_BITS      = 8;
    localparam logic [FRAME_CNT_W-1:0] FRAME_BEATS    = FRAME_CNT_W'(FRAME_BITS / BEAT_BITS);
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_ZERO = 10'h000;
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_ONE  = 10'h001;
    localparam logic [ABILITY_W-1:0]   ABILITY_RST    = 15'h0000;
    localparam logic [LANES-1:0]       LANE_RST       = 4'h0;
    localparam logic [LANES-1:0]       LANE_ALL       = 4'hf;
    localparam logic [TAPS_W-1:0]      TAPS_RST       = 6'h00;
    localparam logic [SEED_W-1:0]      SEED_RST       = 11'h7ff;
    localparam logic [SEED_W-1:0]      SEED_ZERO      = 11'h000;

    // pattern generator taps, x^11 + x^9 + 1
    localparam int PRBS_TAP_HI = 10;
    localparam int PRBS_TAP_LO = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_MISSION = 3'b001,
        ST_TRAIN   = 3'b010,
        ST_TRAINED = 3'b100
    } train_state_t;

    // settings as they arrive from the register interface option
    typedef struct packed {
        logic                training_enable;
        logic                training_restart;
        logic [LANES-1:0]    lane_receiver_done;
        logic [LANES-1:0]    frame_preset_bit;
        logic [LANES-1:0]    frame_init_bit;
        logic [SEED_W-1:0]   lane0_pattern_seed;
        logic [TAPS_W-1:0]   lane0_tap_request;
        logic [TAPS_W-1:0]   lane0_tap_status;
    } lt_settings_t;

endpackage

// File: sim/lt_remote_partner.sv
// far-side station model: latches the training frame fields at each frame start
`timescale 1ns/1ps
`default_nettype none
module lt_remote_partner (
    // clock and frame input
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        start_in,
    input  wire logic [19:0] fields_in,
    // fields as received
    output logic      [19:0] seen_out
);
    // ----------
    // capture
    // ----------
    // only frame starts are sampled, so a mid-frame change never reaches the far side
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_out <= 20'h0_0000;
        end else if (start_in) begin
            seen_out <= fields_in;
        end
    end
endmodule
`default_nettype wire

// File: sim/link_training_control_checker.sv
// assertions on the link training control ports
`timescale 1ns/1ps
`default_nettype none
module link_training_control_checker (
    // inputs
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        adv_gig_kx_ability_in,
    input wire logic        training_enable_in,
    input wire logic        training_restart_in,
    input wire logic [3:0]  lane_receiver_done_in,
    input wire logic [3:0]  frame_preset_bit_in,
    input wire logic [3:0]  frame_init_bit_in,
    // outputs
    input wire logic [14:0] adv_ability_out,
    input wire logic [3:0]  frame_preset_out,
    input wire logic [3:0]  frame_init_out,
    input wire logic [3:0]  lane_receiver_ready_out,
    input wire logic        frame_start_out,
    input wire logic        mission_mode_out,
    input wire logic        training_active_out,
    input wire logic        training_done_out
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    ability_bit_a:
        assert property (!$past(rst_in) |-> adv_ability_out[0] == $past(adv_gig_kx_ability_in))
        else $error("ability bit wrong");
    mission_on_off_a:
        assert property (!training_enable_in |=> mission_mode_out && !training_active_out)
        else $error("no mission mode");
    train_start_a:
        assert property (mission_mode_out && training_enable_in |=> training_active_out
            && frame_start_out) else $error("training not started");
    restart_frame_a:
        assert property (!mission_mode_out && training_enable_in && training_restart_in
            |=> frame_start_out && training_active_out) else $error("restart ignored");
    field_hold_a:
        assert property (!frame_start_out |-> $stable(frame_preset_out) && $stable(frame_init_out))
        else $error("field moved mid frame");
    preset_load_a:
        assert property (frame_start_out |-> frame_preset_out == $past(frame_preset_bit_in))
        else $error("preset not loaded");
    init_load_a:
        assert property (frame_start_out |-> frame_init_out == $past(frame_init_bit_in))
        else $error("init not loaded");
    ready_snap_a:
        assert property (frame_start_out && !$past(mission_mode_out) && !$past(training_restart_in)
            |-> lane_receiver_ready_out == $past(lane_receiver_done_in)) else $error("bad snapshot");
    done_ready_a:
        assert property (training_active_out && training_enable_in && !training_restart_in
            && lane_receiver_ready_out == 4'hf |=> training_done_out) else $error("not done");
    cover property (training_done_out);
    cover property (training_active_out && training_restart_in);
    cover property (mission_mode_out && training_restart_in);
endmodule
bind link_training_control link_training_control_checker i_chk (.*);
`default_nettype wire

// File: sim/link_training_control_tb.sv
// self-checking bench for the link training control block
`timescale 1ns/1ps
`default_nettype none
module link_training_control_tb
    import link_training_pkg::*;
;
    // ----------
    // signals, rows are {ability, preset, init, requests, status}
    // ----------
    logic sys_clk_in, rst_in, training_enable_in, training_restart_in, frame_start_out;
    logic lane0_pattern_bit_out, mission_mode_out, training_active_out, training_done_out;
    logic [3:0] lane_receiver_done_in, frame_preset_bit_in, frame_init_bit_in;
    logic [3:0] frame_preset_out, frame_init_out, lane_receiver_ready_out;
    logic [1:0] lane0_post_tap_request_in, lane0_main_tap_request_in, lane0_pre_tap_request_in;
    logic [1:0] lane0_post_tap_status_in, lane0_main_tap_status_in, lane0_pre_tap_status_in;
    logic [5:0] lane0_tap_request_out, lane0_tap_status_out, reg_req, reg_stat;
    logic reg_bit;
    logic [10:0] lane0_pattern_seed_in;
    logic [14:0] ab, adv_ability_out;
    logic [19:0] fld, seen, prev;
    logic [4:0] st;
    lt_settings_t reg_settings_in;
    int mismatches, checks_done, cycles;
    logic [34:0] rows [6] = '{{15'h0001, 20'h1_81b9}, {15'h4000, 20'ha_5e46},
        {15'h2aaa, 20'hf_06e4}, {15'h5555, 20'h0_fb53}, {15'h7fff, 20'h5_a000},
        {15'h0000, 20'h3_c2d1}};
    assign fld = {frame_preset_out, frame_init_out, lane0_tap_request_out, lane0_tap_status_out};
    assign st = {frame_start_out, mission_mode_out, training_active_out, training_done_out,
        lane0_pattern_bit_out};
    link_training_control i_dut (
        .adv_gig_kx_ability_in(ab[0]), .adv_ten_kx4_ability_in(ab[1]),
        .adv_ten_kr_ability_in(ab[2]), .adv_forty_kr4_ability_in(ab[3]),
        .adv_forty_cr4_ability_in(ab[4]), .adv_hundred_cr10_ability_in(ab[5]),
        .adv_hundred_kp4_ability_in(ab[6]), .adv_hundred_kr4_ability_in(ab[7]),
        .adv_hundred_cr4_ability_in(ab[8]), .adv_twentyfive_krcr_short_ability_in(ab[9]),
        .adv_twentyfive_krcr_ability_in(ab[10]), .adv_twentyfive_kr1_ability_in(ab[11]),
        .adv_twentyfive_cr1_ability_in(ab[12]), .adv_fifty_kr2_ability_in(ab[13]),
        .adv_fifty_cr2_ability_in(ab[14]), .*);
    // register-sourced twin: its direct seed and tap pins sit at zero, so only the
    // register path can bring the row values to its outputs
    assign reg_settings_in = {training_enable_in, training_restart_in, lane_receiver_done_in,
        frame_preset_bit_in, frame_init_bit_in, lane0_pattern_seed_in, lane0_post_tap_request_in,
        lane0_main_tap_request_in, lane0_pre_tap_request_in, lane0_post_tap_status_in,
        lane0_main_tap_status_in, lane0_pre_tap_status_in};
    link_training_control #(.REG_IF_SEL(1'b1)) i_dut_reg (
        .adv_gig_kx_ability_in(ab[0]), .adv_ten_kx4_ability_in(ab[1]),
        .adv_ten_kr_ability_in(ab[2]), .adv_forty_kr4_ability_in(ab[3]),
        .adv_forty_cr4_ability_in(ab[4]), .adv_hundred_cr10_ability_in(ab[5]),
        .adv_hundred_kp4_ability_in(ab[6]), .adv_hundred_kr4_ability_in(ab[7]),
        .adv_hundred_cr4_ability_in(ab[8]), .adv_twentyfive_krcr_short_ability_in(ab[9]),
        .adv_twentyfive_krcr_ability_in(ab[10]), .adv_twentyfive_kr1_ability_in(ab[11]),
        .adv_twentyfive_cr1_ability_in(ab[12]), .adv_fifty_kr2_ability_in(ab[13]),
        .adv_fifty_cr2_ability_in(ab[14]), .lane0_pattern_seed_in(11'h000),
        .lane0_post_tap_request_in(2'h0), .lane0_main_tap_request_in(2'h0),
        .lane0_pre_tap_request_in(2'h0), .lane0_post_tap_status_in(2'h0),
        .lane0_main_tap_status_in(2'h0), .lane0_pre_tap_status_in(2'h0),
        .adv_ability_out(), .frame_preset_out(), .frame_init_out(),
        .lane0_tap_request_out(reg_req), .lane0_tap_status_out(reg_stat),
        .lane_receiver_ready_out(), .frame_start_out(), .lane0_pattern_bit_out(reg_bit),
        .mission_mode_out(), .training_active_out(), .training_done_out(), .*);
    lt_remote_partner i_far (.clk_in(sys_clk_in), .rst_in(rst_in), .start_in(frame_start_out),
        .fields_in(fld), .seen_out(seen));
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks_done++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // fields only move at frame starts, so each far-side look waits for the next frame start
    task automatic wait_start();
        int n;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (frame_start_out !== 1'b1 && n < 700);
        chk("frame start", 20'h0_0001, {19'h0_0000, frame_start_out});
    endtask
    task automatic set_f(input logic [19:0] f);
        {frame_preset_bit_in, frame_init_bit_in, lane0_post_tap_request_in,
            lane0_main_tap_request_in, lane0_pre_tap_request_in, lane0_post_tap_status_in,
            lane0_main_tap_status_in, lane0_pre_tap_status_in} <= f;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            $display("ERROR timeout expected end seen running");
            mismatches++;
            end_sim();
        end
    end
    initial begin
        rst_in = 1'b1;
        ab = 15'h0000;
        {training_enable_in, training_restart_in, lane_receiver_done_in} = 6'h00;
        set_f(20'h0_0000);
        lane0_pattern_seed_in = 11'h2a5;
        prev = 20'h0_0000;
        cyc(5);
        chk("reset state", 20'h0_0009, {15'h0000, st});
        cyc(6);
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        training_enable_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk_in);
            ab <= rows[i][34:20];
            set_f(rows[i][19:0]);
            cyc(3);
            chk("ability", {5'h00, rows[i][34:20]}, {5'h00, adv_ability_out});
            chk("mid frame", prev, fld);
            wait_start();
            cyc(1);
            chk("far fields", rows[i][19:0], seen);
            chk("reg taps", {8'h00, rows[i][11:0]}, {8'h00, reg_req, reg_stat});
            prev = rows[i][19:0];
            $display("row %0d done", i);
        end
        @(posedge sys_clk_in);
        lane_receiver_done_in <= 4'h7;
        wait_start();
        chk("part ready", 20'h0_007a, {12'h000, lane_receiver_ready_out, st[4:1]});
        @(posedge sys_clk_in);
        lane_receiver_done_in <= 4'hf;
        wait_start();
        cyc(1);
        chk("trained", 20'h0_00f1, {12'h000, lane_receiver_ready_out, st[4:1]});
        $display("trained test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk_in);
            lane0_pattern_seed_in <= k ? 11'h000 : 11'h2a5;
            training_restart_in <= 1'b1;
            @(posedge sys_clk_in);
            training_restart_in <= 1'b0;
            #1;
            chk("restart", k ? 20'h0_0015 : 20'h0_0014, {15'h0000, st});
            chk("reg seed", {19'h0_0000, k[0]}, {19'h0_0000, reg_bit});
        end
        @(posedge sys_clk_in);
        training_enable_in <= 1'b0;
        cyc(1);
        chk("disabled", 20'h3_c2d4, {fld[19:4], st[4:1]});
        @(posedge sys_clk_in);
        training_restart_in <= 1'b1;
        cyc(1);
        chk("mission restart", 20'h0_0004, {16'h0000, st[4:1]});
        @(posedge sys_clk_in);
        training_restart_in <= 1'b0;
        training_enable_in <= 1'b1;
        cyc(1);
        chk("re-enabled", 20'h0_000a, {16'h0000, st[4:1]});
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        cyc(2);
        chk("reset again", 20'h0_0009, {15'h0000, st});
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        cyc(3);
        chk("after reset", 20'h0_0002, {16'h0000, st[4:1]});
        $display("control tests done");
        end_sim();
    end
endmodule
`default_nettype wire
